//--- design/rcr_map.vh
// Register address, bit positions, reset values and timing counts of the reset cause block
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

// Register address in special function register space
`define RCR_ADDR 8'hEF

// Bit positions within the reset cause and enable register
`define RCR_BIT_PIN 0
`define RCR_BIT_SUPPLY 1
`define RCR_BIT_CLKLOSS 2
`define RCR_BIT_WDT 3
`define RCR_BIT_SOFT 4
`define RCR_BIT_COMP 5
`define RCR_BIT_FLASH 6
`define RCR_BIT_UNUSED 7

// Power-on value of the cause flags: only the power and supply flag is set
`define RCR_FLAGS_RESET 7'h02

// Power-on value of the source enables (comparator, clock loss, supply monitor)
`define RCR_ENABLE_RESET 1'b0

// Power-on level of the synchronised inputs {clock loss, comparator, supply ok, pin}
`define RCR_SYNC_RESET 4'h7

// System clock period and least hold time of the system reset
`define RCR_CLK_PERIOD_NS 10
`define RCR_HOLD_NS 100
`define RCR_HOLD_CYC ((`RCR_HOLD_NS + `RCR_CLK_PERIOD_NS - 1) / `RCR_CLK_PERIOD_NS)

// Watchdog clock divide ratio from the system clock
`define RCR_WDT_DIV 12

`endif

//--- design/rcr_wdt_prescale.v
// Watchdog clock enable: one pulse every DIV system clock cycles
`timescale 1ns/1ps
`include "rcr_map.vh"

module rcr_wdt_prescale #(
	parameter DIV = `RCR_WDT_DIV,
	parameter CW = 4
) (
	input wire clk, // System clock
	input wire nrst, // Synchronous reset, active low
	input wire restart, // Restart the divider from zero
	output reg tick_reg // One-cycle enable pulse at the divided rate
);

	localparam [31:0] LAST_FULL = DIV - 1;
	localparam [CW-1:0] LAST = LAST_FULL[CW-1:0];

	reg [CW-1:0] count_reg;
	reg [CW-1:0] count_next;

	// Next count wraps at the end of each period
	always @* begin
		if (restart || (count_reg == LAST)) begin
			count_next = {CW{1'b0}};
		end else begin
			count_next = count_reg + {{(CW-1){1'b0}}, 1'b1};
		end
	end

	// Counter and pulse flip-flops
	always @(posedge clk) begin
		if (!nrst) begin
			count_reg <= {CW{1'b0}};
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg <= !restart && (count_reg == LAST);
		end
	end

endmodule // rcr_wdt_prescale

//--- design/rcr_reset_cause.v
// Reset cause and reset source enable register with the system reset sequencer
`timescale 1ns/1ps
`include "rcr_map.vh"

// Notes on behaviour
// R1: Flash fault reset sets bit 6; read only.
// R2: Bit 5 comparator cause flag; write enables comparator.
// R3: Writing 1 to bit 4 forces reset.
// R4: Bit 4 reads 1 after software reset.
// R5: Bit 3 watchdog overflow cause; read only.
// R6: Writing 1 to bit 2 enables clock loss.
// R7: Enabled clock loss detector forces system reset.
// R8: Bit 2 reads 1 only after clock loss.
// R9: Writing 1 to bit 1 enables supply monitor.
// R10: Software enables supply reset after monitor settles.
// R11: Bit 1 set on power-on or supply reset.
// R12: Other flags undefined while bit 1 set.
// R13: Bit 0 pin reset cause; read only.
// R14: Software uses whole-byte writes, no read-modify-write.
// R15: Enabled comparator holds reset while input low.
// R16: Watchdog enabled after reset, clocked clock/12.
// R17: Internal resets never drive the reset pin.
// R18: Bit 7 reads zero, writes ignored.
// R19: Read-only flags change only on reset.
module rcr_reset_cause #(
	parameter HOLD_CYCLES = `RCR_HOLD_CYC,
	parameter HW = 8
) (
	input wire clk, // System clock, 100 MHz
	input wire nrst, // Power-on reset, synchronous, active low
	input wire [7:0] sfrAddr, // Special function register address
	input wire sfrWr, // Register write strobe, one cycle
	input wire sfrRd, // Register read strobe, one cycle
	input wire [7:0] sfrWdata, // Write data
	output reg [7:0] sfrRdata_reg, // Read data, valid the cycle after sfrRd
	input wire extResetPinN, // External reset pin level, active low
	input wire supplyAboveThreshold, // Supply monitor output, high while supply is good
	input wire comparatorHigh, // Comparator output, high while noninverting above inverting
	input wire clockLossTimeout, // Clock loss one-shot timed out, active high
	input wire flashFault, // Illegal flash access pulse, same clock
	input wire watchdogOverflow, // Watchdog overflow pulse, same clock
	input wire watchdogDisable, // Watchdog disable pulse from software, same clock
	output reg systemReset_reg, // System reset to the rest of the chip, active high
	output reg watchdogEnable_reg, // Watchdog running
	output wire watchdogTick, // Watchdog clock enable pulse, one in twelve cycles
	output reg clockLossEnable_reg, // Clock loss detector armed
	output reg rstPinOeN_reg // Reset pin output enable, active low; never driven
);

	localparam [1:0] ST_RUN = 2'b01;
	localparam [1:0] ST_HOLD = 2'b10;
	localparam [31:0] HOLD_FULL = HOLD_CYCLES - 1;
	localparam [HW-1:0] HOLD_LAST = HOLD_FULL[HW-1:0];
	localparam [3:0] SYNC_INIT = `RCR_SYNC_RESET;

	reg [1:0] state_reg;
	reg [HW-1:0] hold_reg;
	reg [6:0] flags_reg;
	reg [6:0] cause_reg;
	reg [6:0] cause_next;
	reg compEnable_reg;
	reg supplyEnable_reg;
	reg [3:0] sync1_reg;
	reg [3:0] sync2_reg;
	reg [6:0] events;
	wire pinLow;
	wire supplyLow;
	wire compLow;
	wire clockLost;
	wire sfrHit;
	wire writeHit;
	wire levelHold;
	wire holdDone;

	// Address decode shared by reads and writes
	function isOurs;
		input [7:0] addr;
		begin
			isOurs = (addr == `RCR_ADDR);
		end
	endfunction

	// Two-stage synchronisers for the asynchronous sources
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : gSync
			always @(posedge clk) begin
				if (!nrst) begin
					sync1_reg[gi] <= SYNC_INIT[gi];
					sync2_reg[gi] <= SYNC_INIT[gi];
				end else begin
					sync1_reg[gi] <= (gi == 0) ? extResetPinN :
						(gi == 1) ? supplyAboveThreshold :
						(gi == 2) ? comparatorHigh : clockLossTimeout;
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	// Source levels after synchronisation
	assign pinLow = !sync2_reg[0];
	assign supplyLow = !sync2_reg[1];
	assign compLow = !sync2_reg[2];
	assign clockLost = sync2_reg[3];
	assign sfrHit = isOurs(sfrAddr);
	assign writeHit = sfrWr && sfrHit && (state_reg == ST_RUN);
	assign holdDone = (hold_reg == {HW{1'b0}});

	// Sources that keep the chip in reset for as long as they stay active
	assign levelHold = pinLow ||
		(supplyLow && supplyEnable_reg) || // R9
		(compLow && compEnable_reg) || // R15
		(clockLost && clockLossEnable_reg); // R7

	// Reset requests, one bit per cause in register bit order
	always @* begin
		events = 7'h00;
		events[`RCR_BIT_PIN] = pinLow; // R13
		events[`RCR_BIT_SUPPLY] = supplyLow && supplyEnable_reg; // R9
		events[`RCR_BIT_CLKLOSS] = clockLost && clockLossEnable_reg; // R7
		events[`RCR_BIT_WDT] = watchdogOverflow && watchdogEnable_reg; // R5
		events[`RCR_BIT_SOFT] = writeHit && sfrWdata[`RCR_BIT_SOFT]; // R3
		events[`RCR_BIT_COMP] = compLow && compEnable_reg; // R2
		events[`RCR_BIT_FLASH] = flashFault; // R1
	end

	// One cause is kept when several arrive together; supply first, software last
	always @* begin
		cause_next = 7'h00;
		if (events[`RCR_BIT_SUPPLY]) begin
			cause_next[`RCR_BIT_SUPPLY] = 1'b1; // R11
		end else if (events[`RCR_BIT_PIN]) begin
			cause_next[`RCR_BIT_PIN] = 1'b1;
		end else if (events[`RCR_BIT_CLKLOSS]) begin
			cause_next[`RCR_BIT_CLKLOSS] = 1'b1; // R8
		end else if (events[`RCR_BIT_COMP]) begin
			cause_next[`RCR_BIT_COMP] = 1'b1;
		end else if (events[`RCR_BIT_WDT]) begin
			cause_next[`RCR_BIT_WDT] = 1'b1;
		end else if (events[`RCR_BIT_FLASH]) begin
			cause_next[`RCR_BIT_FLASH] = 1'b1;
		end else begin
			cause_next[`RCR_BIT_SOFT] = events[`RCR_BIT_SOFT]; // R4
		end
	end

	// Reset sequencer: enter hold on any request, leave after the least time and no level source
	always @(posedge clk) begin
		if (!nrst) begin
			state_reg <= ST_RUN;
			hold_reg <= {HW{1'b0}};
			cause_reg <= 7'h00;
			systemReset_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_RUN: begin
					if (events != 7'h00) begin
						state_reg <= ST_HOLD;
						hold_reg <= HOLD_LAST;
						cause_reg <= cause_next;
						systemReset_reg <= 1'b1; // R3
					end
				end
				ST_HOLD: begin
					if (!holdDone) begin
						hold_reg <= hold_reg - {{(HW-1){1'b0}}, 1'b1};
					end else if (!levelHold) begin
						state_reg <= ST_RUN; // R15
						systemReset_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= ST_RUN;
					systemReset_reg <= 1'b0;
				end
			endcase
		end
	end

	// Cause flags change only at the end of a reset; writes never touch them
	always @(posedge clk) begin
		if (!nrst) begin
			flags_reg <= `RCR_FLAGS_RESET; // R11 R12
		end else if ((state_reg == ST_HOLD) && holdDone && !levelHold) begin
			flags_reg <= cause_reg; // R19 R1 R5 R13 R4 R8
		end
	end

	// Source enables: written by software; every reset exit clears the comparator and clock loss enables but keeps the supply enable
	always @(posedge clk) begin
		if (!nrst) begin
			compEnable_reg <= `RCR_ENABLE_RESET;
			clockLossEnable_reg <= `RCR_ENABLE_RESET;
			supplyEnable_reg <= `RCR_ENABLE_RESET;
		end else if ((state_reg == ST_HOLD) && holdDone && !levelHold) begin
			compEnable_reg <= 1'b0;
			clockLossEnable_reg <= 1'b0;
		end else if (writeHit) begin
			compEnable_reg <= sfrWdata[`RCR_BIT_COMP]; // R2
			clockLossEnable_reg <= sfrWdata[`RCR_BIT_CLKLOSS]; // R6
			supplyEnable_reg <= sfrWdata[`RCR_BIT_SUPPLY]; // R9 R10 R14
		end
	end

	// Watchdog runs after every reset; software may stop it, the reset exit wins
	always @(posedge clk) begin
		if (!nrst) begin
			watchdogEnable_reg <= 1'b1;
		end else if ((state_reg == ST_HOLD) && holdDone && !levelHold) begin
			watchdogEnable_reg <= 1'b1; // R16
		end else if (watchdogDisable) begin
			watchdogEnable_reg <= 1'b0;
		end
	end

	// Watchdog clock enable, restarted while the chip is held in reset
	rcr_wdt_prescale #(
		.DIV(`RCR_WDT_DIV),
		.CW(4)
	) uPrescale (
		.clk(clk),
		.nrst(nrst),
		.restart(systemReset_reg), // R16
		.tick_reg(watchdogTick)
	);

	// Read port; the unused top bit reads zero
	always @(posedge clk) begin
		if (!nrst) begin
			sfrRdata_reg <= 8'h00;
		end else if (sfrRd && isOurs(sfrAddr)) begin
			sfrRdata_reg <= {1'b0, flags_reg}; // R18
		end else begin
			sfrRdata_reg <= 8'h00;
		end
	end

	// Reset pin stays released; internal causes reset only the chip
	always @(posedge clk) begin
		rstPinOeN_reg <= 1'b1; // R17
	end

endmodule // rcr_reset_cause

//--- testbench/rcr_reset_cause_monitor.sv
// Concurrent checks on the ports of the reset cause block
`timescale 1ns/1ps
module rcr_reset_cause_monitor #(
	parameter HOLD_CYCLES = 10
) (
	input logic clk, // System clock
	input logic nrst, // Reset, active low
	input logic [7:0] sfrAddr, // Register address
	input logic sfrWr, // Write strobe
	input logic sfrRd, // Read strobe
	input logic [7:0] sfrWdata, // Write data
	input logic [7:0] sfrRdata_reg, // Read data
	input logic flashFault, // Flash fault pulse
	input logic watchdogOverflow, // Watchdog overflow pulse
	input logic systemReset_reg, // System reset out
	input logic watchdogEnable_reg, // Watchdog running
	input logic watchdogTick, // Watchdog tick
	input logic clockLossEnable_reg, // Clock loss armed
	input logic rstPinOeN_reg // Pin enable, active low
);
	logic [7:0] holdReg;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Counts the cycles the system reset has stood high
	always @(posedge clk) holdReg <= (!nrst || !systemReset_reg) ? 8'h00 : holdReg + 8'h01;
	// Register hit while running, and a software force write
	sequence sHit; sfrAddr == 8'hEF && !systemReset_reg; endsequence
	sequence sSoft; sfrWr && sfrWdata[4] ##0 sHit; endsequence
	a_unused_zero: assert property (sfrRdata_reg[7] == 1'b0) else $error("bit 7 read as 1");
	a_idle_read_zero: assert property (!(sfrRd && sfrAddr == 8'hEF) |=> sfrRdata_reg == 8'h00)
		else $error("read data without a hit read");
	a_soft_force: assert property (sSoft |=> systemReset_reg) else $error("no soft reset");
	a_flash_reset: assert property (flashFault && !systemReset_reg |=> systemReset_reg)
		else $error("flash fault gave no reset");
	a_wdt_reset: assert property (watchdogOverflow && watchdogEnable_reg && !systemReset_reg
		|=> systemReset_reg) else $error("overflow gave no reset");
	a_pin_undriven: assert property (rstPinOeN_reg == 1'b1) else $error("reset pin driven");
	a_wdt_restart: assert property ($fell(systemReset_reg) |-> watchdogEnable_reg)
		else $error("watchdog off after reset");
	a_tick_spacing: assert property (watchdogTick |=> !watchdogTick [*8])
		else $error("watchdog ticks too close");
	a_hold_min: assert property ($fell(systemReset_reg) |-> holdReg >= HOLD_CYCLES)
		else $error("system reset too short");
	a_clkloss_en: assert property (sfrWr && !sfrWdata[4] ##0 sHit
		|=> clockLossEnable_reg == $past(sfrWdata[2])) else $error("clock loss enable");
endmodule // rcr_reset_cause_monitor

//--- testbench/rcr_reset_cause_tb.sv
// Self-checking bench for the reset cause block
`timescale 1ns/1ps
module rcr_reset_cause_tb;
	logic clk = 0, nrst = 0, sfrWr = 0, sfrRd = 0, extResetPinN = 1, supplyAboveThreshold = 1;
	logic comparatorHigh = 1, clockLossTimeout = 0, flashFault = 0, watchdogOverflow = 0;
	logic watchdogDisable = 0, systemReset_reg, watchdogEnable_reg, watchdogTick;
	logic clockLossEnable_reg, rstPinOeN_reg;
	logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata_reg, a;
	logic [7:0] enTab [0:6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h20, 8'h02, 8'h10};
	logic [7:0] expTab [0:6] = '{8'h40, 8'h08, 8'h01, 8'h04, 8'h20, 8'h02, 8'h10};
	int mismatches = 0, check_count = 0, i, n;
	// Clock of 10 ns
	always #5 clk = ~clk;
	rcr_reset_cause #(.HOLD_CYCLES(2)) u_dut (.clk(clk), .nrst(nrst), .sfrAddr(sfrAddr),
		.sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata_reg(sfrRdata_reg),
		.extResetPinN(extResetPinN), .supplyAboveThreshold(supplyAboveThreshold),
		.comparatorHigh(comparatorHigh), .clockLossTimeout(clockLossTimeout),
		.flashFault(flashFault), .watchdogOverflow(watchdogOverflow),
		.watchdogDisable(watchdogDisable), .systemReset_reg(systemReset_reg),
		.watchdogEnable_reg(watchdogEnable_reg), .watchdogTick(watchdogTick),
		.clockLossEnable_reg(clockLossEnable_reg), .rstPinOeN_reg(rstPinOeN_reg));
	// Compare and count
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One register write, then one register read
	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		sfrAddr <= ad;
		sfrWdata <= d;
		sfrWr <= 1'b1;
		@(posedge clk);
		sfrWr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] ad, input logic [7:0] e);
		@(posedge clk);
		sfrAddr <= ad;
		sfrRd <= 1'b1;
		@(posedge clk);
		sfrRd <= 1'b0;
		#1;
		chk(sfrRdata_reg, e);
	endtask
	// Bounded wait for a system reset level
	task waitLvl(input logic lvl);
		#1;
		n = 0;
		while (systemReset_reg !== lvl && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 60) begin
			mismatches++;
			end_of_test;
		end
	endtask
	// Drives one reset source active or idle
	task setSrc(input int s, input logic on);
		case (s)
			0: flashFault <= on;
			1: watchdogOverflow <= on;
			2: extResetPinN <= !on;
			3: clockLossTimeout <= on;
			4: comparatorHigh <= !on;
			5: supplyAboveThreshold <= !on;
			default: ;
		endcase
	endtask
	initial begin
		a = $urandom(32'h46c5);
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(8'hEF, 8'h02);
		chk({rstPinOeN_reg, watchdogEnable_reg}, 8'h03);
		for (i = 0; i < 7; i++) begin
			if (enTab[i] != 8'h00)
				wr(8'hEF, enTab[i]);
			if (i == 3)
				chk(clockLossEnable_reg, 8'h01);
			@(posedge clk);
			setSrc(i, 1'b1);
			waitLvl(1'b1);
			repeat ((i > 1 && i < 6) ? 6 : 0) @(posedge clk);
			#1;
			chk(systemReset_reg, 8'h01);
			@(posedge clk);
			setSrc(i, 1'b0);
			waitLvl(1'b0);
			chk({clockLossEnable_reg, watchdogEnable_reg}, 8'h01);
			rd(8'hEF, expTab[i]);
		end
		// Overflow with the watchdog stopped must not reset
		@(posedge clk);
		watchdogDisable <= 1'b1;
		@(posedge clk);
		watchdogDisable <= 1'b0;
		watchdogOverflow <= 1'b1;
		@(posedge clk);
		watchdogOverflow <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({watchdogEnable_reg, systemReset_reg}, 8'h00);
		// Watchdog clock enable comes once every twelve system clocks
		n = 0;
		while (watchdogTick !== 1'b1 && n < 30) begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (watchdogTick !== 1'b1 && n < 30);
		chk(n, 8'h0C);
		// Random writes to read-only bits and unmapped places
		for (i = 0; i < 40; i++) begin
			a = $urandom;
			if (a == 8'hEF)
				a = 8'h00;
			wr(8'hEF, $urandom & 8'hC9);
			wr(a, $urandom);
			rd(a, 8'h00);
			rd(8'hEF, 8'h10);
		end
		end_of_test;
	end
endmodule // rcr_reset_cause_tb
bind rcr_reset_cause rcr_reset_cause_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.clk(clk),
	.nrst(nrst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata),
	.sfrRdata_reg(sfrRdata_reg), .flashFault(flashFault), .watchdogOverflow(watchdogOverflow),
	.systemReset_reg(systemReset_reg), .watchdogEnable_reg(watchdogEnable_reg),
	.watchdogTick(watchdogTick), .clockLossEnable_reg(clockLossEnable_reg),
	.rstPinOeN_reg(rstPinOeN_reg));
